//--- core/fbod_device.sv
// fbod device end: bus decode, command latches, burst and protection
//
// Overview of operation
// - bank one only when top bits 11
// - write-protect pin guards top small sector
// - secured region overlays boot sector when enabled
// - host starts operations with command writes
// - command held in latches, not addressable
// - bad sequence recovered by reset command
// - read drives array data on all lines
// - async write latches address and data
// - protection read returns one or zero
// - burst start address loaded on valid
// - each burst clock advances address and data
// - chip select high ends burst, floats
// - hardware reset ends burst, floats
// - new address abandons burst, restarts
// - reset low returns to reset state
// - async read after reset, config selects sync
`timescale 1ns/1ps
`include "fbod_params.svh"
module fbod_device (
	input wire logic core_clk,
	input wire logic arst_n,
	fbod_if.device bus,
	input wire logic [`FBOD_DW-1:0] array_rdata,
	input wire logic [`FBOD_DW-1:0] secure_rdata,
	input wire logic secure_enable,
	input wire logic [6:0] prot_sector_set,
	input wire logic persistent_protect_bit,
	output logic [`FBOD_AW-1:0] array_addr,
	output logic bank_sel,
	output logic [6:0] sector_index,
	output logic sector_protected,
	output logic cmd_valid,
	output logic [`FBOD_AW-1:0] cmd_addr,
	output logic [`FBOD_DW-1:0] cmd_data,
	output logic sync_mode,
	output logic [6:0] op_onehot
);
	//////////////////////////////////////////////////////////////////////
	// two-flop synchronisers for every pin
	localparam int NS = 8;
	logic [NS-1:0] pin_raw;
	logic [NS-1:0] s1_r;
	logic [NS-1:0] s2_r;
	logic [`FBOD_AW-1:0] a1_r;
	logic [`FBOD_AW-1:0] a2_r;
	logic [`FBOD_DW-1:0] d1_r;
	logic [`FBOD_DW-1:0] d2_r;
	assign pin_raw = {bus.id_high_voltage, bus.wp_n, bus.address_valid_n, bus.clk_burst,
		bus.reset_n, bus.we_n, bus.oe_n, bus.ce_n};
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			// idle levels, so no false burst clock edge follows reset
			s1_r <= `FBOD_PIN_IDLE;
			s2_r <= `FBOD_PIN_IDLE;
			a1_r <= '0;
			a2_r <= '0;
			d1_r <= '0;
			d2_r <= '0;
		end else begin
			s1_r <= pin_raw;
			s2_r <= s1_r;
			a1_r <= bus.addr;
			a2_r <= a1_r;
			d1_r <= bus.data_lines;
			d2_r <= d1_r;
		end
	end
	logic ce_n;
	logic oe_n;
	logic we_n;
	logic rst_n;
	logic bclk;
	logic adv_n;
	logic wp_n;
	logic vid;
	assign {vid, wp_n, adv_n, bclk, rst_n, we_n, oe_n, ce_n} = s2_r;

	//////////////////////////////////////////////////////////////////////
	// bus operation decode
	fbod_pkg::fbod_op_e op;
	always_comb begin
		if (!rst_n) op = fbod_pkg::FBOD_OP_RESET;
		else if (ce_n) op = fbod_pkg::FBOD_OP_STANDBY;
		else if (!we_n && oe_n) op = fbod_pkg::FBOD_OP_WRITE;
		else if (!oe_n && we_n && vid && a2_r[7:0] == `FBOD_PROT_LOW_BYTE) op = fbod_pkg::FBOD_OP_PROT;
		else if (!oe_n && we_n) op = fbod_pkg::FBOD_OP_READ;
		else if (!adv_n) op = fbod_pkg::FBOD_OP_LOAD;
		else op = fbod_pkg::FBOD_OP_ODIS;
	end
	assign op_onehot = op;

	//////////////////////////////////////////////////////////////////////
	// state: command latch, config, burst address
	logic cmd_valid_r, cmd_valid_nxt;
	logic [`FBOD_AW-1:0] cmd_addr_r, cmd_addr_nxt;
	logic [`FBOD_DW-1:0] cmd_data_r, cmd_data_nxt;
	logic sync_r, sync_nxt;
	logic bursting_r, bursting_nxt;
	logic [`FBOD_AW-1:0] baddr_r, baddr_nxt;
	logic we_d_r;
	logic bclk_d_r;
	logic [`FBOD_AW-1:0] prev_addr_r;
	logic we_rise;
	logic bclk_rise;
	assign we_rise = we_n && !we_d_r;
	assign bclk_rise = bclk && !bclk_d_r;
	always_comb begin
		cmd_valid_nxt = 1'b0;
		cmd_addr_nxt = cmd_addr_r;
		cmd_data_nxt = cmd_data_r;
		sync_nxt = sync_r;
		bursting_nxt = bursting_r;
		baddr_nxt = baddr_r;
		if (op == fbod_pkg::FBOD_OP_RESET) begin
			sync_nxt = 1'b0;
			bursting_nxt = 1'b0;
		end else if (op == fbod_pkg::FBOD_OP_STANDBY) begin
			bursting_nxt = 1'b0;
		end else if (we_rise && !ce_n && oe_n) begin
			// latched at the end of the write strobe, not at an array address
			cmd_valid_nxt = 1'b1;
			cmd_addr_nxt = a2_r;
			cmd_data_nxt = d2_r;
			if (d2_r[7:0] == `FBOD_CMD_RESET) bursting_nxt = 1'b0;
			if (d2_r[7:0] == `FBOD_CMD_CFG) sync_nxt = !d2_r[`FBOD_CFG_SYNC_BIT];
		end else if (sync_r && op == fbod_pkg::FBOD_OP_LOAD) begin
			bursting_nxt = 1'b1;
			baddr_nxt = a2_r;
		end else if (sync_r && !ce_n && oe_n && we_n && a2_r != prev_addr_r) begin
			bursting_nxt = 1'b1;
			baddr_nxt = a2_r;
		end else if (bursting_r && !oe_n && we_n && adv_n && bclk_rise) begin
			baddr_nxt = baddr_r + 20'h1;
		end
	end
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cmd_valid_r <= 1'b0;
			cmd_addr_r <= '0;
			cmd_data_r <= '0;
			sync_r <= 1'b0;
			bursting_r <= 1'b0;
			baddr_r <= '0;
			we_d_r <= 1'b1;
			bclk_d_r <= 1'b0;
			prev_addr_r <= '0;
		end else begin
			cmd_valid_r <= cmd_valid_nxt;
			cmd_addr_r <= cmd_addr_nxt;
			cmd_data_r <= cmd_data_nxt;
			sync_r <= sync_nxt;
			bursting_r <= bursting_nxt;
			baddr_r <= baddr_nxt;
			we_d_r <= we_n;
			bclk_d_r <= bclk;
			prev_addr_r <= a2_r;
		end
	end
	assign cmd_valid = cmd_valid_r;
	assign cmd_addr = cmd_addr_r;
	assign cmd_data = cmd_data_r;
	assign sync_mode = sync_r;

	//////////////////////////////////////////////////////////////////////
	// address, bank and sector decode
	logic [`FBOD_AW-1:0] eff_addr;
	assign eff_addr = (sync_r && bursting_r) ? baddr_r : a2_r;
	assign array_addr = eff_addr;
	assign bank_sel = (eff_addr[`FBOD_BANK_MSB:`FBOD_BANK_LSB] == `FBOD_BANK1_CODE);
	always_comb begin
		// small sectors only in the top region keep the index short
		if (eff_addr >= `FBOD_SMALL_REGION_BASE)
			sector_index = `FBOD_SMALL_SECT_IDX_BASE + 7'(eff_addr[13:`FBOD_SECT_SMALL_SHIFT]);
		else
			sector_index = 7'(eff_addr[`FBOD_AW-1:`FBOD_SECT_LARGE_SHIFT]);
	end
	logic top_small_sector;
	assign top_small_sector = (eff_addr >= `FBOD_TOP_SECT_BASE);
	assign sector_protected = prot_sector_set[0] || (top_small_sector && !wp_n);
	logic in_boot;
	assign in_boot = (eff_addr >= `FBOD_BOOT_SECT_BASE) && !top_small_sector;

	//////////////////////////////////////////////////////////////////////
	// data output, registered
	logic [`FBOD_DW-1:0] dq_r, dq_nxt;
	logic dq_oe_r, dq_oe_nxt;
	always_comb begin
		dq_nxt = '0;
		dq_oe_nxt = 1'b0;
		if (op == fbod_pkg::FBOD_OP_PROT) begin
			dq_oe_nxt = 1'b1;
			dq_nxt = persistent_protect_bit ? `FBOD_PROT_SET_DATA : `FBOD_PROT_CLR_DATA;
		end else if (op == fbod_pkg::FBOD_OP_READ) begin
			dq_oe_nxt = 1'b1;
			dq_nxt = (secure_enable && in_boot) ? secure_rdata : array_rdata;
		end
	end
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			dq_r <= '0;
			dq_oe_r <= 1'b0;
		end else begin
			dq_r <= dq_nxt;
			dq_oe_r <= dq_oe_nxt;
		end
	end
	// reset pin floats the bus at once, not a cycle late
	assign bus.dev_dq_o = dq_r;
	assign bus.dev_dq_oe = dq_oe_r && bus.reset_n && !bus.ce_n && !bus.oe_n;
endmodule

//--- core/fbod_params.svh
// fbod constants: widths, field positions, codes and reset values
`ifndef FBOD_PARAMS_SVH
`define FBOD_PARAMS_SVH
`define FBOD_AW 20
`define FBOD_DW 32
`define FBOD_BANK_MSB 19
`define FBOD_BANK_LSB 18
`define FBOD_BANK1_CODE 2'h3
`define FBOD_TOP_SECT_BASE 20'hFF800
`define FBOD_SMALL_REGION_BASE 20'hFC000
`define FBOD_BOOT_SECT_BASE 20'hFF000
`define FBOD_PROT_LOW_BYTE 8'h02
`define FBOD_PROT_SET_DATA 32'h00000001
`define FBOD_PROT_CLR_DATA 32'h00000000
`define FBOD_CFG_SYNC_BIT 15
`define FBOD_CMD_RESET 8'hF0
`define FBOD_CMD_CFG 8'hD0
`define FBOD_SECT_SMALL_SHIFT 11
`define FBOD_SECT_LARGE_SHIFT 14
`define FBOD_SMALL_SECT_IDX_BASE 7'h46
`define FBOD_STROBE_CYCLES 2
// pin sync reset: {vid, wp_n, adv_n, bclk, rst_n, we_n, oe_n, ce_n} at their idle levels
`define FBOD_PIN_IDLE 8'h6F
`endif

//--- core/fbod_pkg.sv
// fbod package: bus operations and states
package fbod_pkg;
	typedef enum logic [6:0] {
		FBOD_OP_RESET = 7'h01,
		FBOD_OP_STANDBY = 7'h02,
		FBOD_OP_READ = 7'h04,
		FBOD_OP_WRITE = 7'h08,
		FBOD_OP_ODIS = 7'h10,
		FBOD_OP_LOAD = 7'h20,
		FBOD_OP_PROT = 7'h40
	} fbod_op_e;
	typedef enum logic [2:0] {
		FBOD_HS_IDLE = 3'h1,
		FBOD_HS_DRIVE = 3'h2,
		FBOD_HS_DONE = 3'h4
	} fbod_hstate_e;
endpackage

//--- core/fbod_if.sv
// fbod interface: parallel flash bus between host and device
`timescale 1ns/1ps
`include "fbod_params.svh"
interface fbod_if;
	logic ce_n;
	logic oe_n;
	logic we_n;
	logic reset_n;
	logic clk_burst;
	logic address_valid_n;
	logic wp_n;
	logic id_high_voltage;
	logic [`FBOD_AW-1:0] addr;
	logic [`FBOD_DW-1:0] host_dq_o;
	logic host_dq_oe;
	logic [`FBOD_DW-1:0] dev_dq_o;
	logic dev_dq_oe;
	logic [`FBOD_DW-1:0] data_lines;
	assign data_lines = dev_dq_oe ? dev_dq_o : (host_dq_oe ? host_dq_o : '0);
	modport host (output ce_n, oe_n, we_n, reset_n, clk_burst, address_valid_n, wp_n, id_high_voltage,
		addr, host_dq_o, host_dq_oe, input data_lines);
	modport device (input ce_n, oe_n, we_n, reset_n, clk_burst, address_valid_n, wp_n, id_high_voltage,
		addr, data_lines, output dev_dq_o, dev_dq_oe);
endinterface

//--- core/fbod_host.sv
// fbod host end: drives bus cycles from a simple request port
`timescale 1ns/1ps
`include "fbod_params.svh"
module fbod_host (
	input wire logic core_clk,
	input wire logic arst_n,
	fbod_if.host bus,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic req_prot,
	input wire logic req_burst,
	input wire logic req_hw_reset,
	input wire logic [`FBOD_AW-1:0] req_addr,
	input wire logic [`FBOD_DW-1:0] req_wdata,
	input wire logic burst_clk_in,
	input wire logic wp_n_in,
	output logic req_ready,
	output logic rsp_valid,
	output logic [`FBOD_DW-1:0] rsp_rdata
);
	//////////////////////////////////////////////////////////////////////
	// one request at a time; strobe held a fixed number of cycles
	fbod_pkg::fbod_hstate_e st_r, st_nxt;
	logic [2:0] cnt_r, cnt_nxt;
	logic last_cyc;
	logic wr_r, wr_nxt;
	logic prot_r, prot_nxt;
	logic bst_r, bst_nxt;
	logic hrst_r, hrst_nxt;
	logic [`FBOD_AW-1:0] addr_r, addr_nxt;
	logic [`FBOD_DW-1:0] wd_r, wd_nxt;
	logic rv_r, rv_nxt;
	logic [`FBOD_DW-1:0] rd_r, rd_nxt;
	// long enough for the device's pin sync, load and output register
	assign last_cyc = (cnt_r == 3'(`FBOD_STROBE_CYCLES + 2));
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		wr_nxt = wr_r;
		prot_nxt = prot_r;
		bst_nxt = bst_r;
		hrst_nxt = hrst_r;
		addr_nxt = addr_r;
		wd_nxt = wd_r;
		rv_nxt = 1'b0;
		rd_nxt = rd_r;
		case (st_r)
			fbod_pkg::FBOD_HS_IDLE: begin
				if (req_valid) begin
					st_nxt = fbod_pkg::FBOD_HS_DRIVE;
					cnt_nxt = '0;
					wr_nxt = req_write;
					prot_nxt = req_prot;
					bst_nxt = req_burst;
					hrst_nxt = req_hw_reset;
					addr_nxt = req_addr;
					wd_nxt = req_wdata;
				end
			end
			fbod_pkg::FBOD_HS_DRIVE: begin
				cnt_nxt = cnt_r + 3'h1;
				// same clock as the device, so the bus is read directly
				if (last_cyc) begin
					st_nxt = fbod_pkg::FBOD_HS_DONE;
					rd_nxt = bus.data_lines;
					rv_nxt = !wr_r && !hrst_r;
				end
			end
			fbod_pkg::FBOD_HS_DONE: st_nxt = fbod_pkg::FBOD_HS_IDLE;
			default: st_nxt = fbod_pkg::FBOD_HS_IDLE;
		endcase
	end
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= fbod_pkg::FBOD_HS_IDLE;
			cnt_r <= '0;
			wr_r <= 1'b0;
			prot_r <= 1'b0;
			bst_r <= 1'b0;
			hrst_r <= 1'b0;
			addr_r <= '0;
			wd_r <= '0;
			rv_r <= 1'b0;
			rd_r <= '0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			wr_r <= wr_nxt;
			prot_r <= prot_nxt;
			bst_r <= bst_nxt;
			hrst_r <= hrst_nxt;
			addr_r <= addr_nxt;
			wd_r <= wd_nxt;
			rv_r <= rv_nxt;
			rd_r <= rd_nxt;
		end
	end
	logic act;
	assign act = (st_r == fbod_pkg::FBOD_HS_DRIVE);
	assign req_ready = (st_r == fbod_pkg::FBOD_HS_IDLE);
	assign rsp_valid = rv_r;
	assign rsp_rdata = rd_r;

	//////////////////////////////////////////////////////////////////////
	// pin drive; burst mode reads keep oe high to load, then low to stream
	assign bus.reset_n = !(act && hrst_r);
	assign bus.ce_n = !(act && !hrst_r);
	// we rises a cycle before ce and data drop, so the device latch still sees both
	assign bus.we_n = !(act && wr_r && !last_cyc);
	assign bus.oe_n = !(act && !wr_r && !(bst_r && cnt_r == 3'h0));
	assign bus.address_valid_n = !(act && bst_r && cnt_r == 3'h0);
	assign bus.clk_burst = bst_r && burst_clk_in;
	assign bus.id_high_voltage = act && prot_r;
	assign bus.addr = prot_r ? {addr_r[`FBOD_AW-1:8], `FBOD_PROT_LOW_BYTE} : addr_r;
	assign bus.wp_n = wp_n_in;
	assign bus.host_dq_o = wd_r;
	assign bus.host_dq_oe = act && wr_r;
endmodule

//--- dv/fbod_checker.sv
// fbod checker: pin relations between host and device ends
`timescale 1ns/1ps
`include "fbod_params.svh"
module fbod_checker (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic reset_n,
	input wire logic id_high_voltage,
	input wire logic [`FBOD_AW-1:0] addr,
	input wire logic host_dq_oe,
	input wire logic [`FBOD_DW-1:0] dev_dq_o,
	input wire logic dev_dq_oe
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// read combination; four samples cover the two-flop pin sync plus output register
	wire rd = !ce_n && !oe_n && we_n && reset_n;
	////////////////////////////////////////
	property p_rst_float; !reset_n |-> !dev_dq_oe; endproperty
	a_rst_float: assert property (p_rst_float) else $error("device drives in reset");
	property p_standby; ce_n |-> !dev_dq_oe; endproperty
	a_standby: assert property (p_standby) else $error("device drives in standby");
	property p_odis; oe_n |-> !dev_dq_oe; endproperty
	a_odis: assert property (p_odis) else $error("device drives with oe high");
	property p_wr_float; !we_n |-> !dev_dq_oe; endproperty
	a_wr_float: assert property (p_wr_float) else $error("device drives during write");
	property p_read; rd [*4] |-> dev_dq_oe; endproperty
	a_read: assert property (p_read) else $error("device silent on read");
	property p_prot; (rd && id_high_voltage && addr[7:0] == `FBOD_PROT_LOW_BYTE) [*4] |-> dev_dq_o[31:1] == 31'h0;
	endproperty
	a_prot: assert property (p_prot) else $error("status upper bits set");
	property p_hwrite; host_dq_oe |-> oe_n && !dev_dq_oe; endproperty
	a_hwrite: assert property (p_hwrite) else $error("host drives while oe low");
	property p_hread; !oe_n |-> we_n ##1 (oe_n || we_n); endproperty
	a_hread: assert property (p_hread) else $error("host reads and writes together");
endmodule

//--- dv/tb_flash_bus_operation_decode.sv
// fbod bench: host and device ends joined, random and corner traffic
`timescale 1ns/1ps
`include "fbod_params.svh"
module tb_flash_bus_operation_decode;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic req_valid = 1'b0, req_write = 1'b0, req_prot = 1'b0, req_burst = 1'b0, req_hw_reset = 1'b0;
	logic burst_clk_in = 1'b0, wp_n_in = 1'b1, secure_enable = 1'b0, persistent_protect_bit = 1'b0;
	logic [19:0] req_addr = 20'h0, a = 20'h0;
	logic [31:0] req_wdata = 32'h0, secure_rdata = 32'hC3C3C3C3, lfsr_s = 32'h5A;
	logic [6:0] prot_sector_set = 7'h00;
	logic req_ready, rsp_valid, bank_sel, sector_protected, cmd_valid, sync_mode, bs, sp;
	logic [31:0] rsp_rdata, cmd_data, array_rdata;
	logic [19:0] array_addr, cmd_addr;
	logic [6:0] sector_index, si, oh;
	logic [6:0] op_onehot;
	logic [19:0] corner [8] = '{20'h0, 20'hBFFFF, 20'hC0000, 20'hFBFFF, 20'hFC000, 20'hFF7FF, 20'hFF800, 20'hFFFFF};
	int error_cnt = 0, num_checks = 0, cyc = 0;
	fbod_if bus_if ();
	fbod_host u_fbod_host (.core_clk(core_clk), .arst_n(arst_n), .bus(bus_if), .req_valid(req_valid),
		.req_write(req_write), .req_prot(req_prot), .req_burst(req_burst), .req_hw_reset(req_hw_reset),
		.req_addr(req_addr), .req_wdata(req_wdata), .burst_clk_in(burst_clk_in), .wp_n_in(wp_n_in),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
	fbod_device u_fbod_device (.core_clk(core_clk), .arst_n(arst_n), .bus(bus_if), .array_rdata(array_rdata),
		.secure_rdata(secure_rdata), .secure_enable(secure_enable), .prot_sector_set(prot_sector_set),
		.persistent_protect_bit(persistent_protect_bit), .array_addr(array_addr), .bank_sel(bank_sel),
		.sector_index(sector_index), .sector_protected(sector_protected), .cmd_valid(cmd_valid),
		.cmd_addr(cmd_addr), .cmd_data(cmd_data), .sync_mode(sync_mode), .op_onehot(op_onehot));
	fbod_checker u_fbod_checker (.core_clk(core_clk), .arst_n(arst_n), .ce_n(bus_if.ce_n), .oe_n(bus_if.oe_n),
		.we_n(bus_if.we_n), .reset_n(bus_if.reset_n), .id_high_voltage(bus_if.id_high_voltage),
		.addr(bus_if.addr), .host_dq_oe(bus_if.host_dq_oe), .dev_dq_o(bus_if.dev_dq_o), .dev_dq_oe(bus_if.dev_dq_oe));
	////////////////////////////////////////
	always #5 core_clk = ~core_clk;
	// array content is a pure function of address, so any word is predictable
	function automatic logic [31:0] exp_rd(input logic [19:0] x);
		return {x[11:0], x} ^ 32'h5A5A5A5A;
	endfunction
	function automatic logic [6:0] exp_sect(input logic [19:0] x);
		return (x[19:14] == 6'h3F) ? 7'h46 + {4'h0, x[13:11]} : {1'b0, x[19:14]};
	endfunction
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	assign array_rdata = exp_rd(array_addr);
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			summarize();
		end
	end
	// k: 0 read, 1 write, 2 status, 3 burst, 4 pin reset; request held until taken
	task automatic op(input int k, input logic [19:0] x, input logic [31:0] d);
		int n;
		n = 0;
		req_valid <= 1'b1;
		req_write <= k == 1;
		req_prot <= k == 2;
		req_burst <= k == 3;
		req_hw_reset <= k == 4;
		req_addr <= x;
		req_wdata <= d;
		do begin
			@(posedge core_clk);
			n++;
		end while (req_ready !== 1'b1 && n < 40);
		req_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
			// one burst clock rise while the burst streams
			if (n == 2 && k == 3) burst_clk_in <= 1'b1;
			// decode settles two sync stages after the pins
			if (n == 4) begin
				bs = bank_sel;
				si = sector_index;
				sp = sector_protected;
				oh = op_onehot;
			end
		end while (((k == 1) ? cmd_valid : (k == 4 || rsp_valid)) !== 1'b1 && n < 20);
		chk("answer", (k == 1) ? cmd_valid : (k == 4 || rsp_valid), 1'b1);
		if (k == 1) begin
			chk("cmd_addr", cmd_addr, x);
			chk("cmd_data", cmd_data, d);
		end
	endtask
	////////////////////////////////////////
	initial begin
		repeat (20) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		chk("sync_mode", sync_mode, 0);
		chk("op idle", op_onehot, 7'h02);
		for (int i = 0; i < 24; i++) begin
			lfsr_s = lfsr(lfsr_s);
			a = (i < 8) ? corner[i] : lfsr_s[19:0];
			wp_n_in <= lfsr_s[31];
			prot_sector_set <= lfsr_s[26:20];
			op(0, a, 0);
			chk("read data", rsp_rdata, exp_rd(a));
			chk("bank_sel", bs, a[19:18] == 2'h3);
			chk("op read", oh, 7'h04);
			chk("sector_index", si, exp_sect(a));
			chk("protected", sp, lfsr_s[20] | (!lfsr_s[31] && a[19:11] == 9'h1FF));
		end
		$display("test async_read done");
		secure_enable <= 1'b1;
		op(0, 20'hFF123, 0);
		chk("overlay", rsp_rdata, secure_rdata);
		op(0, 20'hFE800, 0);
		chk("beside overlay", rsp_rdata, exp_rd(20'hFE800));
		secure_enable <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			persistent_protect_bit <= i[0];
			op(2, {lfsr_s[19:8], 8'h02}, 0);
			chk("status", rsp_rdata, i ? `FBOD_PROT_SET_DATA : `FBOD_PROT_CLR_DATA);
			chk("op status", oh, 7'h40);
		end
		$display("test overlay_status done");
		op(1, lfsr_s[19:0], {lfsr_s[31:8], 8'h11});
		op(1, 20'h00555, 32'h000000F0);
		op(0, 20'h12345, 0);
		chk("read after reset cmd", rsp_rdata, exp_rd(20'h12345));
		op(1, 20'h0, 32'h000000D0);
		repeat (4) @(posedge core_clk);
		chk("sync_mode", sync_mode, 1);
		op(3, 20'h40010, 0);
		chk("burst first", rsp_rdata, exp_rd(20'h40010));
		chk("burst advance", array_addr, 20'h40011);
		burst_clk_in <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk("burst ended", array_addr, 20'h40010);
		op(4, 0, 0);
		repeat (4) @(posedge core_clk);
		chk("sync_mode", sync_mode, 0);
		op(0, 20'hC0004, 0);
		chk("read after pin reset", rsp_rdata, exp_rd(20'hC0004));
		$display("test commands_burst done");
		summarize();
	end
endmodule
